// >>> design/dmbm_mapper.sv
// data memory bank mapper with its storage and register slave
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module dmbm_mapper
  import dmbm_pkg::*;
(
  input  wire logic        aclk,        // core clock
  input  wire logic        aresetn,     // sync reset, low
  input  wire logic        cpu_req,     // data access request
  input  wire logic        cpu_sel,     // access selector bit
  input  wire logic [7:0]  cpu_off,     // opcode offset
  input  wire logic        cpu_we,      // write access
  input  wire logic [7:0]  cpu_wdata,   // write byte
  input  wire logic        extended_instruction_enable, // alt map
  input  wire logic [11:0] fsr2_base,   // index base, alt map
  output logic      [11:0] cpu_addr,    // resolved address
  output logic      [7:0]  cpu_rdata,   // read byte
  output logic             cpu_ack,     // access done
  output logic             cpu_discard, // bank unimplemented
  output logic             cpu_indirect,// indirect port hit
  output logic             cpu_special, // special area hit
  input  wire logic [11:0] s_axi_awaddr,  // write address
  input  wire logic [2:0]  s_axi_awprot,  // unused
  input  wire logic        s_axi_awvalid, // address valid
  output logic             s_axi_awready, // address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // byte lanes
  input  wire logic        s_axi_wvalid,  // data valid
  output logic             s_axi_wready,  // data ready
  output logic      [1:0]  s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // response valid
  input  wire logic        s_axi_bready,  // response ready
  input  wire logic [11:0] s_axi_araddr,  // read address
  input  wire logic [2:0]  s_axi_arprot,  // unused
  input  wire logic        s_axi_arvalid, // address valid
  output logic             s_axi_arready, // address ready
  output logic      [31:0] s_axi_rdata,   // read data
  output logic      [1:0]  s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // data valid
  input  wire logic        s_axi_rready   // data ready
);
  dmbm_state_t s_q;
  dmbm_state_t s_d;
  logic [11:0] map_addr;
  logic        map_special;
  logic        map_indir;
  logic        map_disc;
  logic        ram_we;
  logic [7:0]  ram_rdata;
  logic        cpu_bank_wr;

  // resolve the opcode offset into a full address
  always_comb begin
    if (cpu_sel) begin
      map_addr = {s_q.bank, cpu_off};
    end else if (cpu_off >= `DMBM_ACC_SPLIT) begin
      map_addr = {`DMBM_SPEC_BANK, cpu_off};
    end else if (extended_instruction_enable) begin
      map_addr = fsr2_base + {4'h0, cpu_off};
    end else begin
      map_addr = {`DMBM_LOW_BANK, cpu_off};
    end
  end

  always_comb begin
    map_special = (map_addr >= `DMBM_SPEC_BASE);
    map_indir = (map_addr == `DMBM_ADR_IND0) ||
                (map_addr == `DMBM_ADR_IND1) ||
                (map_addr == `DMBM_ADR_IND2);
    map_disc  = ({1'b0, map_addr[11:8]} >= `DMBM_BANK_COUNT);
    cpu_bank_wr = cpu_req && cpu_we && !map_disc &&
                  (map_addr == `DMBM_ADR_BANK);
    ram_we    = cpu_req && cpu_we && !map_disc && !map_special;
  end

  dmbm_store u_store (
    .aclk  (aclk),
    .we    (ram_we),
    .addr  (map_addr),
    .wdata (cpu_wdata),
    .rdata (ram_rdata)
  );

  always_comb begin
    s_d = s_q;
    // cpu side: every request answered at the next edge
    s_d.cpu_ack = cpu_req;
    if (cpu_req) begin
      s_d.cpu_addr     = map_addr;
      s_d.cpu_special  = map_special;
      s_d.cpu_indirect = map_indir;
      s_d.cpu_discard  = map_disc;
      if (map_disc || map_indir) begin
        s_d.cpu_rdata = 8'h00;
      end else if (map_addr == `DMBM_ADR_BANK) begin
        s_d.cpu_rdata = {4'h0, s_q.bank};
      end else if (map_special) begin
        s_d.cpu_rdata = 8'h00;
      end else begin
        s_d.cpu_rdata = ram_rdata;
      end
      if (cpu_bank_wr) begin
        s_d.bank = cpu_wdata[3:0];
      end
    end

    // register slave, write side
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_q.awready) begin
      s_d.awaddr  = s_axi_awaddr;
      s_d.aw_have = 1'b1;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
      s_d.w_have = 1'b1;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = `DMBM_RESP_OKAY;
      if ({s_q.awaddr[11:2], 2'b00} == `DMBM_ADR_BANK) begin
        // the core's own write wins a same-cycle clash
        if (s_q.wstrb[0] && !cpu_bank_wr) begin
          s_d.bank = s_q.wdata[3:0];
        end
      end else if ({s_q.awaddr[11:2], 2'b00} != `DMBM_AXI_STAT) begin
        s_d.bresp = `DMBM_RESP_SLVERR;
      end
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;

    // register slave, read side
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `DMBM_RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if ({s_axi_araddr[11:2], 2'b00} == `DMBM_ADR_BANK) begin
        s_d.rdata[3:0] = s_q.bank;
      end else if ({s_axi_araddr[11:2], 2'b00} == `DMBM_AXI_STAT) begin
        s_d.rdata[11:0]             = s_q.cpu_addr;
        s_d.rdata[`DMBM_STAT_DISC]  = s_q.cpu_discard;
        s_d.rdata[`DMBM_STAT_INDIR] = s_q.cpu_indirect;
        s_d.rdata[`DMBM_STAT_SPEC]  = s_q.cpu_special;
      end else begin
        s_d.rresp = `DMBM_RESP_SLVERR;
      end
    end
    s_d.arready = !s_d.rvalid;

    if (!aresetn) begin
      s_d         = '0;
      s_d.bank    = `DMBM_BANK_RST;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
      s_d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign cpu_addr      = s_q.cpu_addr;
  assign cpu_rdata     = s_q.cpu_rdata;
  assign cpu_ack       = s_q.cpu_ack;
  assign cpu_discard   = s_q.cpu_discard;
  assign cpu_indirect  = s_q.cpu_indirect;
  assign cpu_special   = s_q.cpu_special;
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = s_q.rdata;

  // checks on the mapping and the slave
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_low_map: assert property (
    cpu_req && !cpu_sel && !extended_instruction_enable && cpu_off < 8'h60
    |=> cpu_addr == {4'h0, $past(cpu_off)})
    else $error("low access offset not mapped to bank zero");

  chk_high_map: assert property (
    cpu_req && !cpu_sel && cpu_off >= 8'h60
    |=> cpu_addr == {4'hF, $past(cpu_off)} && cpu_special)
    else $error("high access offset not mapped to top bank");

  chk_banked_form: assert property (
    cpu_req && cpu_sel |=> cpu_addr == {$past(s_q.bank), $past(cpu_off)})
    else $error("banked address not formed from bank pointer");

  chk_bank_ignored: assert property (
    cpu_req && !cpu_sel && !extended_instruction_enable
    |=> cpu_addr[11:8] == 4'h0 || cpu_addr[11:8] == 4'hF)
    else $error("access map used bank pointer");

  chk_one_cycle: assert property (
    cpu_req |=> cpu_ack ##1 (cpu_ack == $past(cpu_req)))
    else $error("access not completed in one cycle");

  chk_extended_instruction_enable_map: assert property (
    cpu_req && !cpu_sel && extended_instruction_enable && cpu_off < 8'h60
    |=> cpu_addr == $past(fsr2_base) + {4'h0, $past(cpu_off)})
    else $error("alternative access map not applied");

  chk_bank_write: assert property (
    cpu_bank_wr
    |=> s_q.bank == $past(cpu_wdata[3:0]) && cpu_rdata[7:4] == 4'h0)
    else $error("bank pointer write not taken");

  chk_special_zero: assert property (
    cpu_ack && cpu_special && cpu_addr != 12'hFE0 |-> cpu_rdata == 8'h00)
    else $error("unassigned special address read nonzero");

  chk_indir_zero: assert property (
    cpu_ack && cpu_indirect |-> cpu_rdata == 8'h00 && cpu_special)
    else $error("indirect port returned stored data");

  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  chk_axi_bank_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'hFE0
    |=> s_axi_rvalid && s_axi_rdata == {28'h0, $past(s_q.bank)})
    else $error("bank pointer read wrong over bus");

  cov_access_low: cover property (cpu_req && !cpu_sel && cpu_off < 8'h60);
  cov_access_high: cover property (cpu_req && !cpu_sel && cpu_off >= 8'h60);
  cov_banked: cover property (cpu_req && cpu_sel && s_q.bank != 4'h0);
  cov_axi_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : dmbm_mapper

// >>> common/dmbm_defines.svh
// constants of the data memory bank mapper
// How it works
// - access bank: 256 slots, bank0 low, bank15 top
// - one 8-bit offset spans both halves seamlessly
// - selector 1: bank pointer above opcode offset
// - selector 0: access map, bank pointer ignored
// - access bank access completes in one cycle
// - general storage starts at 000h upward
// - general storage untouched by any reset
// - special area decoded F60h through FFFh
// - unassigned special addresses read zero
// - indirect port addresses hold no storage
// - extended enable selects alternative access map
// - bank pointer: four bits, upper read zero
// - unimplemented bank: drop writes, read zero
`ifndef DMBM_DEFINES_SVH
`define DMBM_DEFINES_SVH
`define DMBM_ADR_BANK    12'hFE0
`define DMBM_AXI_STAT    12'h000
`define DMBM_ADR_IND0    12'hFEF
`define DMBM_ADR_IND1    12'hFE7
`define DMBM_ADR_IND2    12'hFDF
`define DMBM_ACC_SPLIT   8'h60
`define DMBM_SPEC_BASE   12'hF60
`define DMBM_SPEC_BANK   4'hF
`define DMBM_LOW_BANK    4'h0
`define DMBM_STORE_DEPTH 3936
`define DMBM_BANK_COUNT  5'h10
`define DMBM_BANK_RST    4'h0
`define DMBM_STAT_DISC   12
`define DMBM_STAT_INDIR  13
`define DMBM_STAT_SPEC   14
`define DMBM_RESP_OKAY   2'h0
`define DMBM_RESP_SLVERR 2'h2
`endif

// >>> common/dmbm_pkg.sv
// types of the data memory bank mapper
`include "dmbm_defines.svh"
package dmbm_pkg;
  typedef struct packed {
    logic [3:0]  bank;
    logic [11:0] awaddr;
    logic        aw_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        w_have;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [11:0] cpu_addr;
    logic [7:0]  cpu_rdata;
    logic        cpu_ack;
    logic        cpu_discard;
    logic        cpu_indirect;
    logic        cpu_special;
  } dmbm_state_t;

  typedef struct packed {
    logic [`DMBM_STORE_DEPTH-1:0][7:0] mem;
  } dmbm_store_t;
endpackage : dmbm_pkg

// >>> design/dmbm_store.sv
// general storage array, flip-flops with no reset
`timescale 1ns/10ps
module dmbm_store
  import dmbm_pkg::*;
(
  input  wire logic        aclk,  // core clock
  input  wire logic        we,    // write strobe
  input  wire logic [11:0] addr,  // storage index
  input  wire logic [7:0]  wdata, // write byte
  output logic      [7:0]  rdata  // read byte, combinational
);
  dmbm_store_t s_q;
  dmbm_store_t s_d;

  always_comb begin
    s_d = s_q;
    if (we && (addr < 12'(`DMBM_STORE_DEPTH))) begin
      s_d.mem[addr] = wdata;
    end
  end

  // no reset term: contents survive every reset
  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign rdata = (addr < 12'(`DMBM_STORE_DEPTH)) ? s_q.mem[addr] : 8'h00;
endmodule : dmbm_store

// >>> tb/dmbm_cpu_model.sv
// cpu side model issuing single byte data accesses
`timescale 1ns/10ps
module dmbm_cpu_model (
  input  wire logic       aclk,      // core clock
  output logic            cpu_req,   // access request
  output logic            cpu_sel,   // access selector
  output logic      [7:0] cpu_off,   // opcode offset
  output logic            cpu_we,    // write access
  output logic      [7:0] cpu_wdata  // write byte
);
  initial begin
    cpu_req   = 1'b0;
    cpu_sel   = 1'b0;
    cpu_off   = 8'h00;
    cpu_we    = 1'b0;
    cpu_wdata = 8'h00;
  end

  // one request cycle; the answer is settled 1 ns after the following edge
  task automatic access(input logic s, input logic [7:0] o, input logic w, input logic [7:0] d);
    @(posedge aclk);
    cpu_req   <= 1'b1;
    cpu_sel   <= s;
    cpu_off   <= o;
    cpu_we    <= w;
    cpu_wdata <= d;
    @(posedge aclk);
    cpu_req   <= 1'b0;
    cpu_wdata <= ~d;
    #1;
  endtask : access
endmodule : dmbm_cpu_model

// >>> tb/tb_dmbm_mapper.sv
// self-checking bench of the data memory bank mapper
`timescale 1ns/10ps
module tb_dmbm_mapper;
  import dmbm_pkg::*;
  logic        aclk, aresetn, ext_en, cpu_req, cpu_sel, cpu_we, cpu_ack, cpu_discard, cpu_indirect, cpu_special;
  logic [7:0]  cpu_off, cpu_wdata, cpu_rdata;
  logic [11:0] fsr2_base, cpu_addr, s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [24:0] row;
  int          error_cnt, cmp_count;
  // selector, offset, bank pointer, expected address
  logic [24:0] rows [7] = '{{1'b0, 8'h00, 4'h7, 12'h000}, {1'b0, 8'h5F, 4'h7, 12'h05F},
                            {1'b0, 8'h60, 4'h7, 12'hF60}, {1'b0, 8'hFF, 4'h3, 12'hFFF},
                            {1'b1, 8'h5F, 4'h7, 12'h75F}, {1'b1, 8'h60, 4'hF, 12'hF60},
                            {1'b1, 8'h12, 4'h0, 12'h012}};

  dmbm_cpu_model dmbm_cpu_model_i (.aclk, .cpu_req, .cpu_sel, .cpu_off, .cpu_we, .cpu_wdata);
  dmbm_mapper dmbm_mapper_i (.aclk, .aresetn, .cpu_req, .cpu_sel, .cpu_off, .cpu_we, .cpu_wdata,
    .extended_instruction_enable(ext_en), .fsr2_base, .cpu_addr, .cpu_rdata, .cpu_ack, .cpu_discard,
    .cpu_indirect, .cpu_special, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic cpu(input logic s, input logic [7:0] o, input logic w, input logic [7:0] v);
    dmbm_cpu_model_i.access(s, o, w, v);
    chk({31'h0, cpu_ack}, 32'h1);
  endtask : cpu

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  initial begin
    #200us;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    {ext_en, fsr2_base, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    do_reset();
    axr(12'hFE0, d, r);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      row = rows[i];
      axw(12'hFE0, {28'h0, row[15:12]}, r);
      cpu(row[24], row[23:16], 1'b0, 8'h00);
      chk({20'h0, cpu_addr}, {20'h0, row[11:0]});
      chk({30'h0, cpu_discard, cpu_special}, {31'h0, row[11:0] >= 12'hF60});
    end
    cpu(1'b0, 8'hE0, 1'b1, 8'hA5);
    axr(12'hFE0, d, r);
    chk(d, 32'h5);
    chk({30'h0, r}, 32'h0);
    cpu(1'b0, 8'hE0, 1'b0, 8'h00);
    chk({24'h0, cpu_rdata}, 32'h05);
    cpu(1'b1, 8'h34, 1'b1, 8'h5A);
    cpu(1'b1, 8'h34, 1'b0, 8'h00);
    chk({24'h0, cpu_rdata}, 32'h5A);
    cpu(1'b0, 8'hD5, 1'b1, 8'h3C);
    cpu(1'b0, 8'hD5, 1'b0, 8'h00);
    chk({24'h0, cpu_rdata}, 32'h0);
    cpu(1'b0, 8'hEF, 1'b1, 8'h77);
    cpu(1'b0, 8'hEF, 1'b0, 8'h00);
    chk({23'h0, cpu_indirect, cpu_rdata}, 32'h100);
    axr(12'h000, d, r);
    chk(d, 32'h0000_6FEF);
    axr(12'h004, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    ext_en <= 1'b1;
    fsr2_base <= 12'h100;
    cpu(1'b0, 8'h10, 1'b0, 8'h00);
    chk({20'h0, cpu_addr}, 32'h110);
    cpu(1'b0, 8'h60, 1'b0, 8'h00);
    chk({20'h0, cpu_addr}, 32'hF60);
    ext_en <= 1'b0;
    do_reset();
    axr(12'hFE0, d, r);
    chk(d, 32'h0);
    axw(12'hFE0, 32'h5, r);
    cpu(1'b1, 8'h34, 1'b0, 8'h00);
    chk({24'h0, cpu_rdata}, 32'h5A);
    print_verdict();
  end
endmodule : tb_dmbm_mapper
